// [design/phy_mac_data_interface.sv]
// Contract
// - mii transmit clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s.
// - rmii leaves both clock pins idle and times everything from the reference.
// - serial mode drives the transmit clock at 10 MHz.
// - transmit data sampled on tx clock, or reference in rmii.
// - mii receive clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10.
// - serial mode outputs a 10 MHz receive clock.
// - mii data valid is high while receive nibbles carry valid data.
// - rmii data valid is synchronous and independent of carrier sense.
// - serial mode leaves data valid and receive error unused.
// - mii 100 Mb/s error raised on invalid symbol inside a packet.
// - rmii 100 Mb/s error raised on invalid symbol while crs_dv high.
// - mii and rmii data is corrupted on a symbol error while data valid is high; serial data never is.
// - mii nibbles driven on receive clock, valid only with data valid.
// - rmii dibbles driven on the 50 MHz reference.
// - serial data on one bit framed by carrier; upper lines unused.
// - carrier sense high while medium busy; frames serial data.
// - rmii merges carrier sense and data valid onto one output.
// - collision high on simultaneous tx and rx in half duplex, in mii and serial; rmii holds it low.
// - 10BASE-T half duplex heartbeat pulses collision for about 1 us right after transmit ends.
// - full duplex holds collision low with no heartbeat.
`timescale 1ns/100ps
`default_nettype none
module phy_mac_data_interface
  import phy_mac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] mode_strap,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic heartbeat_en,
  input wire logic ref_clock_input,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire rx_core_s rx_core,
  output logic tx_clk,
  output logic rx_clk,
  output var mac_rx_s mac_rx,
  output logic col,
  output var tx_unit_s tx_unit,
  output logic tx_stb,
  output logic rx_req,
  output var if_mode_e mode,
  output logic mode_valid
);

  typedef struct packed {
    logic latched;
    if_mode_e mode;
    logic ref_prev;
    logic tx_en_prev;
    logic [3:0] rep_cnt;
    logic tx_phase;
    logic [1:0] tx_low;
    tx_unit_s tx_unit;
    logic tx_stb;
    logic rx_phase;
    logic [3:0] rx_nib;
    logic rx_car;
    logic rx_val;
    logic rx_err;
    mac_rx_s mac_rx;
    logic rx_req;
    logic col;
  } main_state_s;

  main_state_s st_r;
  main_state_s st_nxt;

  logic ref_edge;
  logic ref_rise;
  logic div_run;
  logic [DIV_W-1:0] div_num;
  logic [DIV_W-1:0] div_den;
  logic clk_lvl;
  logic clk_rise;
  logic sqe_start;
  logic sqe_active;
  logic rmii_slot;
  logic half_duplex_col;

  function automatic if_mode_e decode_strap(input logic [1:0] strap);
    if_mode_e m;
    case (strap)
      STRAP_RMII: m = MODE_RMII;
      STRAP_SERIAL: m = MODE_SERIAL;
      STRAP_MII: m = MODE_MII;
      default: m = MODE_MII;
    endcase
    return m;
  endfunction : decode_strap

  // replaces a nibble with a fixed pattern when a symbol is bad
  function automatic logic [3:0] rx_payload(input logic [3:0] data, input logic err);
    return err ? RX_CORRUPT_NIB : data;
  endfunction : rx_payload

  assign ref_edge = ref_clock_input ^ st_r.ref_prev;
  assign ref_rise = ref_clock_input & ~st_r.ref_prev;

  // clock ratio per mode and speed
  always_comb begin
    div_run = st_r.latched && (st_r.mode != MODE_RMII);
    div_num = DIV_NUM_MII100;
    div_den = DIV_DEN_MII100;
    case (st_r.mode)
      MODE_MII: begin
        if (!speed_100) begin
          div_num = DIV_NUM_MII10;
          div_den = DIV_DEN_MII10;
        end
      end
      MODE_SERIAL: begin
        div_num = DIV_NUM_SERIAL;
        div_den = DIV_DEN_SERIAL;
      end
      MODE_RMII: begin
        div_num = DIV_NUM_MII100;
        div_den = DIV_DEN_MII100;
      end
      default: begin
        div_num = DIV_NUM_MII100;
        div_den = DIV_DEN_MII100;
      end
    endcase
  end

  frac_div u_clk_div (
    .mclk(mclk),
    .rst(rst),
    .tick(ref_edge),
    .run(div_run),
    .num(div_num),
    .den(div_den),
    .clk_o(clk_lvl),
    .rise(clk_rise),
    .fall()
  );

  // heartbeat only at 10 Mb/s half duplex, mii or serial
  assign sqe_start = st_r.latched && st_r.tx_en_prev && !tx_en && heartbeat_en && !full_duplex
                     && (st_r.mode != MODE_RMII) && ((st_r.mode == MODE_SERIAL) || !speed_100);

  sqe_pulse u_sqe (
    .mclk(mclk),
    .rst(rst),
    .start(sqe_start),
    .active(sqe_active)
  );

  assign rmii_slot = ref_rise && (st_r.rep_cnt == 4'h0);
  assign half_duplex_col = tx_en && rx_core.carrier;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ref_prev = ref_clock_input;
    st_nxt.tx_en_prev = tx_en;
    st_nxt.tx_stb = 1'b0;
    st_nxt.rx_req = 1'b0;

    if (!st_r.latched) begin
      st_nxt.latched = 1'b1;
      st_nxt.mode = decode_strap(mode_strap);
      st_nxt.tx_en_prev = 1'b0;
    end else begin
      case (st_r.mode)
        MODE_MII: begin
          if (clk_rise) begin
            // one clock both samples transmit and launches receive
            st_nxt.tx_unit.en = tx_en;
            st_nxt.tx_unit.data = txd;
            st_nxt.tx_stb = tx_en;
            st_nxt.rx_req = 1'b1;
            st_nxt.mac_rx.dv = rx_core.valid;
            st_nxt.mac_rx.crs = rx_core.carrier;
            st_nxt.mac_rx.er = rx_core.sym_err && rx_core.valid && speed_100;
            st_nxt.mac_rx.rxd = rx_core.valid ? rx_payload(rx_core.data, rx_core.sym_err)
                                              : RXD_IDLE;
          end
        end
        MODE_RMII: begin
          if (ref_rise) begin
            if (st_r.rep_cnt == 4'h0) begin
              st_nxt.rep_cnt = speed_100 ? RMII_REPEAT_100M : RMII_REPEAT_10M;
            end else begin
              st_nxt.rep_cnt = st_r.rep_cnt - 4'h1;
            end
          end
          if (rmii_slot) begin
            // transmit: two dibbles, low first, make one nibble
            if (!tx_en) begin
              st_nxt.tx_phase = 1'b0;
              st_nxt.tx_unit.en = 1'b0;
            end else if (!st_r.tx_phase) begin
              st_nxt.tx_low = txd[1:0];
              st_nxt.tx_phase = 1'b1;
            end else begin
              st_nxt.tx_unit.en = 1'b1;
              st_nxt.tx_unit.data = {txd[1:0], st_r.tx_low};
              st_nxt.tx_stb = 1'b1;
              st_nxt.tx_phase = 1'b0;
            end
            // receive: fetch a nibble, send low dibble then high
            if (!st_r.rx_phase) begin
              st_nxt.rx_req = 1'b1;
              st_nxt.rx_car = rx_core.carrier;
              st_nxt.rx_val = rx_core.valid;
              st_nxt.rx_err = rx_core.sym_err && speed_100 && (rx_core.carrier || rx_core.valid);
              st_nxt.rx_nib = rx_core.valid ? rx_payload(rx_core.data, rx_core.sym_err) : RXD_IDLE;
              st_nxt.mac_rx.rxd = {2'h0, st_nxt.rx_nib[1:0]};
              st_nxt.mac_rx.dv = rx_core.valid;
              // with carrier gone, crs_dv drops on the first dibble of a nibble
              st_nxt.mac_rx.crs = rx_core.carrier;
              st_nxt.mac_rx.er = st_nxt.rx_err;
              st_nxt.rx_phase = rx_core.carrier || rx_core.valid;
            end else begin
              st_nxt.mac_rx.rxd = {2'h0, st_r.rx_nib[3:2]};
              st_nxt.mac_rx.dv = st_r.rx_val;
              st_nxt.mac_rx.crs = st_r.rx_car || st_r.rx_val;
              st_nxt.mac_rx.er = st_r.rx_err;
              st_nxt.rx_phase = 1'b0;
            end
          end
        end
        MODE_SERIAL: begin
          if (clk_rise) begin
            st_nxt.tx_unit.en = tx_en;
            st_nxt.tx_unit.data = {3'h0, txd[0]};
            st_nxt.tx_stb = tx_en;
            st_nxt.rx_req = 1'b1;
            st_nxt.mac_rx.dv = 1'b0;
            st_nxt.mac_rx.er = 1'b0;
            st_nxt.mac_rx.crs = rx_core.carrier;
            st_nxt.mac_rx.rxd = {3'h0, rx_core.carrier & rx_core.data[0]};
          end
        end
        default: begin
          st_nxt.mode = MODE_MII;
        end
      endcase

      // collision is held low in rmii; the mac derives it itself
      if (st_r.mode == MODE_RMII || full_duplex) begin
        st_nxt.col = 1'b0;
      end else begin
        st_nxt.col = half_duplex_col || sqe_active;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_clk = clk_lvl;
  assign rx_clk = clk_lvl;
  assign mac_rx = st_r.mac_rx;
  assign col = st_r.col;
  assign tx_unit = st_r.tx_unit;
  assign tx_stb = st_r.tx_stb;
  assign rx_req = st_r.rx_req;
  assign mode = st_r.mode;
  assign mode_valid = st_r.latched;

endmodule : phy_mac_data_interface
`default_nettype wire

// [design/phy_mac_pkg.sv]
package phy_mac_pkg;

  // timing of the system clock and of the heartbeat pulse
  localparam int unsigned MCLK_PERIOD_NS = 25;
  localparam int unsigned SQE_TIME_NS = 1000;
  localparam int unsigned SQE_CYCLES = (SQE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned SQE_W = 6;
  localparam logic [SQE_W-1:0] SQE_LOAD = SQE_W'(SQE_CYCLES);

  // fractional divider ratios: toggles per reference edge = num / den
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_NUM_MII100 = 4'h1;
  localparam logic [DIV_W-1:0] DIV_DEN_MII100 = 4'h1;
  localparam logic [DIV_W-1:0] DIV_NUM_MII10 = 4'h1;
  localparam logic [DIV_W-1:0] DIV_DEN_MII10 = 4'hA;
  localparam logic [DIV_W-1:0] DIV_NUM_SERIAL = 4'h2;
  localparam logic [DIV_W-1:0] DIV_DEN_SERIAL = 4'h5;

  // rmii at 10 Mb/s holds each dibble for ten reference cycles
  localparam logic [3:0] RMII_REPEAT_10M = 4'h9;
  localparam logic [3:0] RMII_REPEAT_100M = 4'h0;

  // interface mode strap encoding
  localparam logic [1:0] STRAP_MII = 2'h0;
  localparam logic [1:0] STRAP_RMII = 2'h1;
  localparam logic [1:0] STRAP_SERIAL = 2'h2;

  localparam logic [3:0] RX_CORRUPT_NIB = 4'hE;
  localparam logic [3:0] RXD_IDLE = 4'h0;

  typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_SERIAL} if_mode_e;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } tx_unit_s;

  typedef struct packed {
    logic carrier;
    logic valid;
    logic sym_err;
    logic [3:0] data;
  } rx_core_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic crs;
    logic [3:0] rxd;
  } mac_rx_s;

  typedef struct packed {
    logic [DIV_W-1:0] acc;
    logic lvl;
  } frac_div_state_s;

  typedef struct packed {
    logic [SQE_W-1:0] cnt;
  } sqe_state_s;

endpackage : phy_mac_pkg

// [design/frac_div.sv]
`timescale 1ns/100ps
`default_nettype none
module frac_div
  import phy_mac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire logic [DIV_W-1:0] num,
  input wire logic [DIV_W-1:0] den,
  output logic clk_o,
  output logic rise,
  output logic fall
);

  frac_div_state_s st_r;
  frac_div_state_s st_nxt;
  logic wrap;
  logic [DIV_W:0] sum;

  always_comb begin
    st_nxt = st_r;
    wrap = 1'b0;
    sum = {1'b0, st_r.acc} + {1'b0, num};
    if (!run) begin
      st_nxt.acc = '0;
      st_nxt.lvl = 1'b0;
    end else if (tick) begin
      if (sum >= {1'b0, den}) begin
        wrap = 1'b1;
        st_nxt.acc = DIV_W'(sum - {1'b0, den});
        st_nxt.lvl = ~st_r.lvl;
      end else begin
        st_nxt.acc = sum[DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_o = st_r.lvl;
  assign rise = wrap & ~st_r.lvl;
  assign fall = wrap & st_r.lvl;

endmodule : frac_div
`default_nettype wire

// [design/sqe_pulse.sv]
`timescale 1ns/100ps
`default_nettype none
module sqe_pulse
  import phy_mac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  output logic active
);

  sqe_state_s st_r;
  sqe_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = SQE_LOAD;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = (st_r.cnt != '0);

endmodule : sqe_pulse
`default_nettype wire

// [tb/phy_mac_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module phy_mac_checker
  import phy_mac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic full_duplex,
  input wire logic heartbeat_en,
  input wire logic speed_100,
  input wire logic tx_en,
  input wire rx_core_s rx_core,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire mac_rx_s mac_rx,
  input wire logic col,
  input wire logic tx_stb,
  input wire if_mode_e mode,
  input wire logic mode_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic mii = mode_valid && mode == MODE_MII;
  wire logic ser = mode_valid && mode == MODE_SERIAL;
  mode_hold_a: assert property (mode_valid |=> mode_valid && $stable(mode)) else $error("mode moved");
  rmii_clk_a: assert property (mode_valid && mode == MODE_RMII |-> !tx_clk && !rx_clk)
    else $error("clock runs in rmii");
  clk_pair_a: assert property (tx_clk == rx_clk) else $error("clocks differ");
  stb_rise_a: assert property (tx_stb && mode != MODE_RMII |-> $rose(tx_clk))
    else $error("unit off clock edge");
  ser_unused_a: assert property (ser |-> !mac_rx.dv && !mac_rx.er && mac_rx.rxd[3:1] == 3'h0 &&
    (mac_rx.crs || !mac_rx.rxd[0])) else $error("serial lanes misused");
  dv_gate_a: assert property (mii && !mac_rx.dv |-> mac_rx.rxd == RXD_IDLE) else $error("data without valid");
  err_nib_a: assert property (mii && mac_rx.er |-> mac_rx.rxd == RX_CORRUPT_NIB)
    else $error("error data intact");
  col_off_a: assert property (mode_valid && (full_duplex || mode == MODE_RMII) |=> !col)
    else $error("collision in full duplex");
  col_hit_a: assert property (mode_valid && mode != MODE_RMII && !full_duplex && tx_en && rx_core.carrier |=> col)
    else $error("collision missed");
  heartbeat_col_a: assert property (mii && !speed_100 && !full_duplex && heartbeat_en && $fell(tx_en) |->
    ##[1:3] col [*8]) else $error("heartbeat missing");
  cover property (tx_stb && tx_en);
  cover property (mac_rx.er);
  cover property (col && !tx_en);
endmodule : phy_mac_checker
bind phy_mac_data_interface phy_mac_checker u_chk (.mclk(mclk), .rst(rst), .full_duplex(full_duplex),
  .heartbeat_en(heartbeat_en), .speed_100(speed_100), .tx_en(tx_en), .rx_core(rx_core), .tx_clk(tx_clk),
  .rx_clk(rx_clk), .mac_rx(mac_rx), .col(col), .tx_stb(tx_stb), .mode(mode), .mode_valid(mode_valid));
`default_nettype wire

// [tb/mac_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mac_model (
  input wire logic mclk,
  input wire logic rmii,
  input wire logic [2:0] uw,
  input wire logic ref_clock_input,
  input wire logic tx_clk,
  input wire logic go,
  input wire logic [31:0] frame,
  input wire logic [4:0] units,
  output logic tx_en,
  output logic [3:0] txd,
  output logic busy
);
  logic ref_q = 1'b0, clk_q = 1'b0;
  logic en_q = 1'b0, busy_q = 1'b0;
  logic [3:0] d_q = 4'h0;
  logic [31:0] sh = 32'h0;
  logic [4:0] left = 5'h0;
  assign tx_en = en_q;
  assign txd = d_q;
  assign busy = busy_q;
  always @(posedge mclk) begin
    ref_q <= ref_clock_input;
    clk_q <= tx_clk;
    if (go && !busy_q) begin
      busy_q <= 1'b1;
      sh <= frame;
      left <= units;
    end else if (rmii ? ref_q && !ref_clock_input : tx_clk && !clk_q) begin
      if (busy_q && left != 5'h0) begin
        en_q <= 1'b1;
        d_q <= sh[3:0];
        sh <= sh >> uw;
        left <= left - 5'h1;
      end else begin
        en_q <= 1'b0;
        d_q <= ~d_q;
        busy_q <= 1'b0;
      end
    end
  end
endmodule : mac_model
`default_nettype wire

// [tb/tb_phy_mac_data_interface.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_phy_mac_data_interface
  import phy_mac_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, ref_clock_input = 1'b0, go = 1'b0, rmii = 1'b0;
  logic spd = 1'b1, fdx = 1'b0, hb = 1'b0;
  logic [1:0] strap = 2'h0, rc = 2'h0;
  logic [2:0] uw = 3'h4;
  logic [3:0] msk = 4'hF, txd;
  logic [31:0] frame = 32'h0;
  logic [4:0] units = 5'h0;
  rx_core_s rxc = '0;
  logic tx_en, tx_clk, rx_clk, col, tx_stb, rx_req, mode_valid, busy;
  mac_rx_s mac_rx;
  tx_unit_s tx_unit;
  if_mode_e mode;
  mac_rx_s rxq[$];
  tx_unit_s txq[$];
  int fails = 0, n_compared = 0, seed;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    rc <= rc + 2'h1;
    if (rc == 2'h3) ref_clock_input <= ~ref_clock_input;
  end
  phy_mac_data_interface dut (.mclk(mclk), .rst(rst), .mode_strap(strap), .speed_100(spd), .full_duplex(fdx),
    .heartbeat_en(hb), .ref_clock_input(ref_clock_input), .tx_en(tx_en), .txd(txd), .rx_core(rxc),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .mac_rx(mac_rx), .col(col), .tx_unit(tx_unit), .tx_stb(tx_stb),
    .rx_req(rx_req), .mode(mode), .mode_valid(mode_valid));
  mac_model mac (.mclk(mclk), .rmii(rmii), .uw(uw), .ref_clock_input(ref_clock_input), .tx_clk(tx_clk),
    .go(go), .frame(frame), .units(units), .tx_en(tx_en), .txd(txd), .busy(busy));
  task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask : cmp_val
  task automatic cmp_tx(input tx_unit_s e, input tx_unit_s g);
    cmp_val(16'({e.en, e.data & (rmii ? 4'hF : msk)}), 16'({g.en, g.data & (rmii ? 4'hF : msk)}));
  endtask : cmp_tx
  task automatic cmp_rx(input mac_rx_s e, input mac_rx_s g);
    cmp_val(16'({e.dv, e.er, e.crs, e.rxd & msk}), 16'({g.dv, g.er, g.crs, g.rxd & msk}));
  endtask : cmp_rx
  always @(negedge mclk) begin
    if (tx_stb === 1'b1 && tx_unit.en === 1'b1 && txq.size() > 0) cmp_tx(txq.pop_front(), tx_unit);
    if (rx_req === 1'b1 && rxq.size() > 0) cmp_rx(rxq.pop_front(), mac_rx);
  end
  task automatic start(input logic [1:0] s, input logic sp);
    logic [2:0] w;
    w = s == STRAP_RMII ? 3'h2 : s == STRAP_SERIAL ? 3'h1 : 3'h4;
    @(posedge mclk);
    strap <= s;
    spd <= sp;
    fdx <= 1'b0;
    hb <= 1'b0;
    rxc <= '0;
    rst <= 1'b1;
    rmii <= s == STRAP_RMII;
    uw <= w;
    msk <= 4'((5'h1 << w) - 5'h1);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp_val(16'({1'b1, s}), 16'({mode_valid, mode}));
  endtask : start
  task automatic send(input logic [4:0] n);
    logic [31:0] f;
    int i;
    f = $urandom;
    for (i = 0; i < n; i++)
      if (!rmii || i[0]) txq.push_back({1'b1, 4'(f >> (rmii ? 4 * (i / 2) : i * uw))});
    frame <= f;
    units <= n;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    for (i = 0; busy !== 1'b0 && i < 9000; i++) @(negedge mclk);
    if (busy !== 1'b0) fails++;
    repeat (4) @(posedge mclk);
  endtask : send
  task automatic wait_req;
    int i;
    @(negedge mclk);
    for (i = 0; rx_req !== 1'b1 && i < 400; i++) @(negedge mclk);
    if (rx_req !== 1'b1) fails++;
    @(posedge mclk);
  endtask : wait_req
  task automatic recv(input int n);
    rx_core_s v;
    mac_rx_s e;
    repeat (n) begin
      wait_req();
      v = 7'($urandom);
      v.sym_err = v.sym_err & v.valid;
      rxc <= v;
      e.crs = v.carrier;
      e.dv = strap != STRAP_SERIAL && v.valid;
      e.er = v.sym_err && spd && strap != STRAP_SERIAL;
      e.rxd = strap == STRAP_SERIAL ? {3'h0, v.carrier & v.data[0]} : e.er ? RX_CORRUPT_NIB : e.dv ? v.data : RXD_IDLE;
      rxq.push_back(e);
    end
    wait_req();
  endtask : recv
  task automatic period(input logic [15:0] exp);
    realtime t0;
    @(posedge tx_clk);
    t0 = $realtime;
    @(posedge tx_clk);
    cmp_val(exp, 16'(int'(($realtime - t0) / 25.0)));
  endtask : period
  task automatic col_count(input logic [15:0] exp);
    int c, h;
    h = 0;
    for (c = 0; c < 700; c++) begin
      @(negedge mclk);
      h += int'(col === 1'b1);
    end
    @(posedge mclk);
    cmp_val(exp, 16'(h));
  endtask : col_count
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    #500000;
    fails++;
    final_report();
  end
  initial begin
    seed = $urandom(32'hE923);
    start(STRAP_MII, 1'b1);
    period(16'd8);
    fork send(5'd8); recv(12); join
    $display("test mii 100 done");
    start(STRAP_MII, 1'b0);
    period(16'd80);
    hb <= 1'b1;
    fork send(5'd4); col_count(16'd40); join
    fdx <= 1'b1;
    fork send(5'd4); col_count(16'd0); join
    $display("test mii 10 heartbeat done");
    start(STRAP_SERIAL, 1'b0);
    period(16'd20);
    fork send(5'd8); recv(12); join
    $display("test serial done");
    start(STRAP_RMII, 1'b1);
    fork send(5'd8); recv(12); join
    $display("test rmii done");
    cmp_val(16'(txq.size() + rxq.size()), 16'h0000);
    final_report();
  end
endmodule : tb_phy_mac_data_interface
`default_nettype wire
